/* logic/pwm_seq_regs.svh */
// Constants of the current-mode PWM sequencer: offsets, fields, resets, timing.
// Assumes a 10 MHz pclk; analog thresholds arrive as synchronous digital inputs.
//
// What this block does
// - Feedback above its open-loop level for 130 ms is a fault.
// - Supply undervoltage is also a fault: double hiccup, then restart.
// - Open feedback raises an error flag and starts a timer; recovery resets it.
// - Feedback fault past 130 ms stops the drive and starts the double hiccup.
// - At startup the soft-start level ramps from zero to full over 4 ms, then holds.
// - Modulation level is the least of soft-start level, skip ramp level and feedback level over three.
// - The switching clock sets the gate drive high every cycle while in S_RUN, enabled and out of skip.
// - Gate drive falls once the sensed current reaches the modulation level.
// - Gate drive falls at 80 percent of the switching period regardless.
// - A compensation ramp restarts with each cycle and adds to the sensed current.
// - Switching frequency sweeps linearly within 7.5 percent, repeating about every 6 ms.
// - No drive pulses while feedback lies below the skip threshold.
// - Switching resumes when feedback rises back above the skip threshold.
// - On leaving skip the duty ceiling ramps up over 300 us.
// - Every restart after a double hiccup begins with a fresh soft-start.

`ifndef PWM_SEQ_REGS_SVH
`define PWM_SEQ_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_CONFIG 8'h0c
`define OFS_STATE 8'h10

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define STAT_FB_OPEN_BIT 0
`define STAT_FB_TIMEOUT_BIT 1
`define STAT_UVLO_BIT 2
`define STAT_SKIP_BIT 3
`define STAT_RESTART_BIT 4
`define STAT_WIDTH 5
`define CTRL_RESET 32'h0000_0001
`define MASK_RESET 5'h00
`define CONFIG_RESET 4'h4

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_HZ 10000000
`define SW_FREQ_HZ 65000
`define SS_TIME_US 4000
`define SKIP_RAMP_US 300
`define FAULT_TIME_MS 130
`define JITTER_PERIOD_US 6000
`define JITTER_PERMILLE 75
`define MAX_DUTY_PCT 80
`define HICCUP_CYCLES 2
`define LEVEL_STEPS 255
`define LEVEL_FULL 8'hff
`define SS_CYC (`SS_TIME_US * (`CLK_HZ / 1000000))
`define SKIP_RAMP_CYC (`SKIP_RAMP_US * (`CLK_HZ / 1000000))
`define FAULT_CYC (`FAULT_TIME_MS * (`CLK_HZ / 1000))
`define PERIOD_CYC (`CLK_HZ / `SW_FREQ_HZ)
`define JITTER_SPAN (`PERIOD_CYC * `JITTER_PERMILLE / 1000)
`define JITTER_STEP_CYC ((`JITTER_PERIOD_US * (`CLK_HZ / 1000000)) / (4 * `JITTER_SPAN))

`endif

/* logic/pwm_seq_pkg.sv */
// Types shared by the PWM sequencer modules.
// Assumes nothing beyond the constants header.
package pwm_seq_pkg;
	typedef enum logic [2:0] {
		S_RUN = 3'b001,
		S_DISCHARGE = 3'b010,
		S_CHARGE = 3'b100
	} seq_state_type;
endpackage : pwm_seq_pkg

/* logic/duty_ramp.sv */
// Duty-ceiling ramp: steps an 8-bit level from zero to full scale.
// Assumes restart is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
`include "pwm_seq_regs.svh"
module duty_ramp #(
	parameter int unsigned STEP_CYC = 156
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	output logic [7:0] level
);
	logic [15:0] step_q;
	logic [15:0] step_d;
	logic [7:0] level_q;
	logic [7:0] level_d;

	always_comb
	begin
		step_d = step_q;
		level_d = level_q;
		if (restart)
		begin
			step_d = 16'h0000;
			level_d = 8'h00;
		end
		else if (level_q != `LEVEL_FULL)
		begin
			// Equal steps of one code every STEP_CYC cycles.
			if (step_q >= 16'(STEP_CYC - 1))
			begin
				step_d = 16'h0000;
				level_d = level_q + 8'h01;
			end
			else
			begin
				step_d = step_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			step_q <= 16'h0000;
			level_q <= 8'h00;
		end
		else
		begin
			step_q <= step_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule : duty_ramp

/* logic/current_mode_pwm_sequencer.sv */
// Current-mode PWM sequencer: switching clock, gate latch, ramps, skip and fault hiccup.
// Assumes comparator and supply inputs are synchronous to pclk and an APB master.
`timescale 1ns/1ps
`include "pwm_seq_regs.svh"
module current_mode_pwm_sequencer
	import pwm_seq_pkg::*;
#(
	parameter int unsigned SS_CYC = `SS_CYC,
	parameter int unsigned FAULT_CYC = `FAULT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] cs_level,
	input wire logic [9:0] feedback_level,
	input wire logic feedback_open,
	input wire logic skip_below,
	input wire logic supply_uvlo,
	input wire logic supply_at_latch,
	input wire logic supply_at_on,
	output logic gate_drive,
	output logic startup_fet_en,
	output logic fb_error_flag,
	output logic [7:0] modulation_level,
	output logic irq
);
	localparam int unsigned SS_STEP = (SS_CYC + `LEVEL_STEPS - 1) / `LEVEL_STEPS;
	localparam int unsigned SKIP_STEP = (`SKIP_RAMP_CYC + `LEVEL_STEPS - 1) / `LEVEL_STEPS;

	// ---------------------------------------------------------------
	// Arithmetic helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] min_level(input logic [7:0] a, input logic [7:0] b);
		min_level = (a < b) ? a : b;
	endfunction : min_level

	function automatic logic [7:0] fb_third(input logic [9:0] fb);
		logic [9:0] q;
		q = fb / 10'd3;
		fb_third = (q > 10'h0ff) ? `LEVEL_FULL : q[7:0];
	endfunction : fb_third

	function automatic logic [7:0] max_on(input logic [7:0] period);
		logic [15:0] p;
		p = 16'(period) * 16'(`MAX_DUTY_PCT);
		max_on = 8'(p / 16'd100);
	endfunction : max_on

	function automatic logic [8:0] comp_add(input logic [7:0] on, input logic [3:0] gain);
		logic [11:0] prod;
		prod = 12'(on) * 12'(gain);
		comp_add = {1'b0, prod[11:4]};
	endfunction : comp_add

	// ---------------------------------------------------------------
	// Register file and APB slave
	// ---------------------------------------------------------------
	logic ctrl_en_q, ctrl_en_d;
	logic [`STAT_WIDTH-1:0] status_q, status_d, mask_q, mask_d, events;
	logic [3:0] comp_gain_q, comp_gain_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
	logic acc, done, hit;
	logic [31:0] rd_mux;
	seq_state_type state_q, state_d;
	logic gate_q, gate_d, fb_err_q, fb_err_d;
	logic [7:0] mod_q, mod_d, ss_level, skip_level;

	assign acc = psel && penable;
	assign done = acc && pready_q;

	always_comb
	begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`OFS_CTRL: rd_mux = {31'h0000_0000, ctrl_en_q};
			`OFS_STATUS: rd_mux = {27'h000_0000, status_q};
			`OFS_MASK: rd_mux = {27'h000_0000, mask_q};
			`OFS_CONFIG: rd_mux = {28'h000_0000, comp_gain_q};
			`OFS_STATE: rd_mux = {3'h0, fb_err_q, gate_q, state_q, skip_level, ss_level, mod_q};
			default: hit = 1'b0;
		endcase
	end

	always_comb
	begin
		pready_d = acc && !pready_q;
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (acc && !pready_q)
		begin
			prdata_d = (hit && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr_d = !hit;
		end
		ctrl_en_d = ctrl_en_q;
		mask_d = mask_q;
		comp_gain_d = comp_gain_q;
		status_d = status_q;
		if (done && pwrite && paddr == `OFS_CTRL)
			ctrl_en_d = pwdata[`CTRL_ENABLE_BIT];
		if (done && pwrite && paddr == `OFS_MASK)
			mask_d = pwdata[`STAT_WIDTH-1:0];
		if (done && pwrite && paddr == `OFS_CONFIG)
			comp_gain_d = pwdata[3:0];
		// Only bits that the read reported are cleared; a new event still sets.
		if (done && !pwrite && paddr == `OFS_STATUS)
			status_d = status_q & ~prdata_q[`STAT_WIDTH-1:0];
		status_d = status_d | events;
		irq_d = |(status_d & mask_q);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_en_q <= 1'(`CTRL_RESET);
			mask_q <= `MASK_RESET;
			comp_gain_q <= `CONFIG_RESET;
			status_q <= 5'h00;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			ctrl_en_q <= ctrl_en_d;
			mask_q <= mask_d;
			comp_gain_q <= comp_gain_d;
			status_q <= status_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
		end
	end

	// ---------------------------------------------------------------
	// Switching clock with frequency jitter
	// ---------------------------------------------------------------
	logic [7:0] sw_cnt_q, sw_cnt_d, period_q, period_d, on_cnt_q, on_cnt_d;
	logic [4:0] jit_pos_q, jit_pos_d;
	logic jit_up_q, jit_up_d;
	logic [11:0] jit_cnt_q, jit_cnt_d;
	logic cyc_start;

	assign cyc_start = (sw_cnt_q == 8'h00);

	always_comb
	begin
		jit_cnt_d = jit_cnt_q + 12'h001;
		jit_pos_d = jit_pos_q;
		jit_up_d = jit_up_q;
		// Triangle sweep of the period between its two extremes.
		if (jit_cnt_q >= 12'(`JITTER_STEP_CYC - 1))
		begin
			jit_cnt_d = 12'h000;
			if (jit_up_q)
				jit_pos_d = jit_pos_q + 5'h01;
			else
				jit_pos_d = jit_pos_q - 5'h01;
			if (jit_up_q && jit_pos_q == 5'(2 * `JITTER_SPAN - 1))
				jit_up_d = 1'b0;
			if (!jit_up_q && jit_pos_q == 5'h01)
				jit_up_d = 1'b1;
		end
		period_d = period_q;
		sw_cnt_d = sw_cnt_q + 8'h01;
		if (cyc_start)
			period_d = 8'(`PERIOD_CYC - `JITTER_SPAN) + 8'(jit_pos_q);
		if (sw_cnt_q >= period_q - 8'h01)
			sw_cnt_d = 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			jit_cnt_q <= 12'h000;
			jit_pos_q <= 5'(`JITTER_SPAN);
			jit_up_q <= 1'b1;
			period_q <= 8'(`PERIOD_CYC);
			sw_cnt_q <= 8'h00;
		end
		else
		begin
			jit_cnt_q <= jit_cnt_d;
			jit_pos_q <= jit_pos_d;
			jit_up_q <= jit_up_d;
			period_q <= period_d;
			sw_cnt_q <= sw_cnt_d;
		end
	end

	// ---------------------------------------------------------------
	// Ramps, modulation level and gate latch
	// ---------------------------------------------------------------
	logic ss_restart_q, ss_restart_d, skip_prev_q, skip_resume, run_ok;
	logic [8:0] sense_total;

	duty_ramp #(.STEP_CYC(SS_STEP)) u_ss_ramp (
		.pclk(pclk),
		.presetn(presetn),
		.restart(ss_restart_q),
		.level(ss_level)
	);

	duty_ramp #(.STEP_CYC(SKIP_STEP)) u_skip_ramp (
		.pclk(pclk),
		.presetn(presetn),
		.restart(skip_resume),
		.level(skip_level)
	);

	assign skip_resume = skip_prev_q && !skip_below;
	assign run_ok = (state_q == S_RUN) && ctrl_en_q && !skip_below;
	assign sense_total = {1'b0, cs_level} + comp_add(on_cnt_q, comp_gain_q);

	always_comb
	begin
		mod_d = min_level(min_level(ss_level, skip_level), fb_third(feedback_level));
		gate_d = gate_q;
		on_cnt_d = gate_q ? on_cnt_q + 8'h01 : 8'h00;
		if (!run_ok && !cyc_start)
			gate_d = 1'b0;
		else if (gate_q && on_cnt_q >= max_on(period_q) - 8'h01)
			gate_d = 1'b0;
		else if (gate_q && sense_total >= {1'b0, mod_q})
			gate_d = 1'b0;
		if (cyc_start)
		begin
			gate_d = run_ok;
			on_cnt_d = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mod_q <= 8'h00;
			gate_q <= 1'b0;
			on_cnt_q <= 8'h00;
			skip_prev_q <= 1'b0;
		end
		else
		begin
			mod_q <= mod_d;
			gate_q <= gate_d;
			on_cnt_q <= on_cnt_d;
			skip_prev_q <= skip_below;
		end
	end

	// ---------------------------------------------------------------
	// Fault timer and double hiccup sequencer
	// ---------------------------------------------------------------
	logic [20:0] fault_cnt_q, fault_cnt_d;
	logic [1:0] hic_cnt_q, hic_cnt_d;
	logic fet_q, fet_d, timeout;

	assign timeout = feedback_open && fault_cnt_q >= 21'(FAULT_CYC - 1);

	always_comb
	begin
		state_d = state_q;
		hic_cnt_d = hic_cnt_q;
		ss_restart_d = 1'b0;
		fault_cnt_d = 21'h00_0000;
		fb_err_d = 1'b0;
		events = 5'h00;
		events[`STAT_SKIP_BIT] = skip_below && !skip_prev_q;
		unique case (state_q)
			S_RUN:
			begin
				fb_err_d = feedback_open;
				events[`STAT_FB_OPEN_BIT] = feedback_open && !fb_err_q;
				if (feedback_open)
					fault_cnt_d = fault_cnt_q + 21'h00_0001;
				if (supply_uvlo || timeout)
				begin
					state_d = S_DISCHARGE;
					hic_cnt_d = 2'h0;
					events[`STAT_UVLO_BIT] = supply_uvlo;
					events[`STAT_FB_TIMEOUT_BIT] = timeout;
				end
			end
			S_DISCHARGE:
			begin
				if (supply_at_latch)
					state_d = S_CHARGE;
			end
			S_CHARGE:
			begin
				if (supply_at_on && hic_cnt_q == 2'(`HICCUP_CYCLES - 1))
				begin
					state_d = S_RUN;
					ss_restart_d = 1'b1;
					events[`STAT_RESTART_BIT] = 1'b1;
				end
				else if (supply_at_on)
				begin
					state_d = S_DISCHARGE;
					hic_cnt_d = hic_cnt_q + 2'h1;
				end
			end
			default: state_d = S_DISCHARGE;
		endcase
		fet_d = (state_d == S_CHARGE);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_RUN;
			hic_cnt_q <= 2'h0;
			ss_restart_q <= 1'b0;
			fault_cnt_q <= 21'h00_0000;
			fb_err_q <= 1'b0;
			fet_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			hic_cnt_q <= hic_cnt_d;
			ss_restart_q <= ss_restart_d;
			fault_cnt_q <= fault_cnt_d;
			fb_err_q <= fb_err_d;
			fet_q <= fet_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign gate_drive = gate_q;
	assign startup_fet_en = fet_q;
	assign fb_error_flag = fb_err_q;
	assign modulation_level = mod_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_restart;
		state_q == S_CHARGE && supply_at_on && hic_cnt_q == 2'h1;
	endsequence
	sequence s_fresh_ss;
		state_q == S_RUN ##1 ss_level == 8'h00;
	endsequence
	property p_timeout_hiccup;
		state_q == S_RUN && feedback_open && fault_cnt_q == 21'(FAULT_CYC - 1)
			|=> state_q == S_DISCHARGE ##1 !gate_q;
	endproperty
	a_timeout_hiccup: assert property (p_timeout_hiccup) else $error("no hiccup on timeout");
	property p_uvlo;
		state_q == S_RUN && supply_uvlo |=> state_q == S_DISCHARGE;
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("uvlo did not fault");
	property p_timer_reset;
		state_q == S_RUN && !feedback_open |=> fault_cnt_q == 21'h00_0000 && !fb_err_q;
	endproperty
	a_timer_reset: assert property (p_timer_reset) else $error("fault timer not reset");
	property p_restart_ss;
		s_restart |=> s_fresh_ss;
	endproperty
	a_restart_ss: assert property (p_restart_ss) else $error("no fresh soft start");
	property p_set;
		cyc_start && run_ok |=> gate_q;
	endproperty
	a_set: assert property (p_set) else $error("gate not set at cycle start");
	property p_max_duty;
		gate_q && on_cnt_q == max_on(period_q) - 8'h01 && !cyc_start |=> !gate_q;
	endproperty
	a_max_duty: assert property (p_max_duty) else $error("max duty exceeded");
	property p_sense_off;
		gate_q && !cyc_start && sense_total >= {1'b0, mod_q} |=> !gate_q;
	endproperty
	a_sense_off: assert property (p_sense_off) else $error("gate stayed on at sense");
	property p_skip_quiet;
		skip_below && cyc_start |=> !gate_q [*2];
	endproperty
	a_skip_quiet: assert property (p_skip_quiet) else $error("pulse during skip");
	property p_skip_ramp;
		$fell(skip_below) |=> skip_level == 8'h00 ##1 skip_level <= 8'h01;
	endproperty
	a_skip_ramp: assert property (p_skip_ramp) else $error("skip ramp not restarted");
	property p_ss_mono;
		!ss_restart_q |=> ss_level >= $past(ss_level) && mod_q <= $past(ss_level);
	endproperty
	a_ss_mono: assert property (p_ss_mono) else $error("soft start level fell");
	property p_period_band;
		period_q >= 8'(`PERIOD_CYC - `JITTER_SPAN) && period_q <= 8'(`PERIOD_CYC + `JITTER_SPAN);
	endproperty
	a_period_band: assert property (p_period_band) else $error("period out of band");
endmodule : current_mode_pwm_sequencer

/* testbench/frontend_model.sv */
// Behavioural analog front end: current-sense ramp and supply rail with hiccup thresholds.
// Assumes the gate and startup enable are registered outputs in the pclk domain.
`timescale 1ns/1ps
module frontend_model (
	input wire logic pclk,
	input wire logic [7:0] slope,
	input wire logic gate_drive,
	input wire logic startup_fet_en,
	output logic [7:0] cs_level,
	output logic supply_at_latch,
	output logic supply_at_on
);
	int cs = 0;
	int rail = 40;
	int aux = 200;
	// The auxiliary winding feeds the rail only while switching has been recent.
	always @(posedge pclk)
	begin
		cs <= gate_drive ? cs + slope : 0;
		aux <= gate_drive ? 200 : (aux > 0 ? aux - 1 : 0);
		if (startup_fet_en || aux > 0)
			rail <= rail < 40 ? rail + 1 : 40;
		else
			rail <= rail > 0 ? rail - 1 : 0;
	end
	assign cs_level = cs > 255 ? 8'hff : 8'(cs);
	assign supply_at_latch = rail == 0;
	assign supply_at_on = rail == 40;
endmodule : frontend_model

/* testbench/current_mode_pwm_sequencer_tb.sv */
// Self-checking bench for the PWM sequencer with an APB master and analog front end model.
// Assumes shortened soft-start and fault counts passed as parameters.
`timescale 1ns/1ps
`include "pwm_seq_regs.svh"
module current_mode_pwm_sequencer_tb;
	localparam int SS = 510;
	localparam int FLT = 200;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] cs_level;
	logic [9:0] feedback_level = 10'h3ff;
	logic feedback_open = 1'b0;
	logic skip_below = 1'b0;
	logic supply_uvlo = 1'b0;
	logic supply_at_latch;
	logic supply_at_on;
	logic gate_drive;
	logic startup_fet_en;
	logic fb_error_flag;
	logic [7:0] modulation_level;
	logic irq;
	logic [7:0] slope = 8'h00;
	logic [31:0] seed = 32'h0000_d3b2;
	logic [31:0] rd;
	logic er;
	logic [7:0] prev;
	int miscompares = 0;
	int tests_run = 0;
	int rises;
	int maxw;
	int minp;
	int maxp;
	int k;
	int bad;
	always #50 pclk = ~pclk;
	current_mode_pwm_sequencer #(.SS_CYC(SS), .FAULT_CYC(FLT)) current_mode_pwm_sequencer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cs_level(cs_level), .feedback_level(feedback_level), .feedback_open(feedback_open),
		.skip_below(skip_below), .supply_uvlo(supply_uvlo), .supply_at_latch(supply_at_latch),
		.supply_at_on(supply_at_on), .gate_drive(gate_drive), .startup_fet_en(startup_fet_en),
		.fb_error_flag(fb_error_flag), .modulation_level(modulation_level), .irq(irq));
	frontend_model frontend_model_i (.pclk(pclk), .slope(slope), .gate_drive(gate_drive),
		.startup_fet_en(startup_fet_en), .cs_level(cs_level),
		.supply_at_latch(supply_at_latch), .supply_at_on(supply_at_on));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [7:0] mod_exp(input logic [9:0] fb);
		logic [9:0] q;
		q = fb / 10'd3;
		return (q > 10'd255) ? 8'hff : q[7:0];
	endfunction : mod_exp
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic hang(input int n, input int bound);
		if (n > bound)
		begin
			miscompares++;
			$display("Error at %0t: wait timed out", $time);
			report_and_stop();
		end
	endtask : hang
	task automatic tick(input int n);
		repeat (n) @(negedge pclk);
	endtask : tick
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
			n++;
			hang(n, 50);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
		chk(32'(er), 32'(experr));
	endtask : rdc
	// 0 waits for gate high, 1 for startup enable high, 2 for it low.
	task automatic wait_hi(input int sel, input int bound);
		int n;
		logic v;
		n = 0;
		v = 1'b0;
		while (!v)
		begin
			@(negedge pclk);
			n++;
			v = sel == 0 ? gate_drive === 1'b1 : startup_fet_en === (sel == 1);
			hang(n, bound);
		end
	endtask : wait_hi
	task automatic watch(input int cyc);
		int w;
		int p;
		logic last;
		rises = 0;
		maxw = 0;
		minp = 9999;
		maxp = 0;
		w = 0;
		p = 0;
		last = gate_drive;
		repeat (cyc)
		begin
			@(negedge pclk);
			p++;
			w = gate_drive === 1'b1 ? w + 1 : 0;
			maxw = w > maxw ? w : maxw;
			if (gate_drive === 1'b1 && last !== 1'b1)
			begin
				minp = (rises > 0 && p < minp) ? p : minp;
				maxp = (rises > 0 && p > maxp) ? p : maxp;
				rises++;
				p = 0;
			end
			last = gate_drive;
		end
	endtask : watch
	// Double hiccup, then a fresh soft-start whose length is timed.
	task automatic hiccup();
		int n;
		wait_hi(1, 1000);
		wait_hi(2, 1000);
		wait_hi(1, 1000);
		wait_hi(2, 1000);
		tick(3);
		chk(32'(modulation_level < 8'h04), 1);
		n = 0;
		while (modulation_level !== 8'hff && n < 2000)
		begin
			@(negedge pclk);
			n++;
		end
		chk(32'(n >= 480 && n <= 530), 1);
	endtask : hiccup
	initial
	begin
		repeat (8) @(posedge pclk);
		chk(32'(gate_drive), 0);
		chk(32'(modulation_level), 0);
		presetn <= 1'b1;
		prev = 8'h00;
		bad = 0;
		repeat (3300)
		begin
			@(negedge pclk);
			if (modulation_level < prev || modulation_level > prev + 9'd1)
				bad++;
			prev = modulation_level;
		end
		chk(32'(bad), 0);
		chk(32'(modulation_level), 32'h0000_00ff);
		rdc(`OFS_CTRL, `CTRL_RESET, 1'b0);
		rdc(`OFS_MASK, 32'(`MASK_RESET), 1'b0);
		rdc(`OFS_CONFIG, 32'(`CONFIG_RESET), 1'b0);
		rdc(8'h40, 32'h0000_0000, 1'b1);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge pclk);
			feedback_level <= i == 0 ? 10'd765 : (i == 1 ? 10'd768 : 10'(xs()));
			tick(3);
			chk(32'(modulation_level), 32'(mod_exp(feedback_level)));
		end
		@(posedge pclk);
		feedback_level <= 10'h3ff;
		watch(46000);
		chk(32'(minp >= 142 && maxp <= 164 && rises > 250), 1);
		chk(32'(maxw >= 113 && maxw <= 132), 1);
		chk(32'(minp <= 145 && maxp >= 161), 1);
		@(posedge pclk);
		slope <= 8'(1 + xs() % 3);
		feedback_level <= 10'd180;
		tick(4);
		k = 0;
		while (slope * k + k / 4 < 60)
			k++;
		watch(1000);
		chk(32'(rises > 5 && maxw >= k && maxw <= k + 3), 1);
		// With zero compensation gain only the sensed current ends the pulse.
		apb(1'b1, `OFS_CONFIG, 32'h0000_0000);
		k = (60 + slope - 1) / slope;
		watch(1000);
		chk(32'(rises > 5 && maxw >= k && maxw <= k + 3), 1);
		apb(1'b1, `OFS_CONFIG, 32'(`CONFIG_RESET));
		@(posedge pclk);
		slope <= 8'h00;
		feedback_level <= 10'h3ff;
		skip_below <= 1'b1;
		tick(2);
		watch(500);
		chk(32'(rises), 0);
		@(posedge pclk);
		skip_below <= 1'b0;
		tick(3);
		chk(32'(modulation_level < 8'h04), 1);
		wait_hi(0, 400);
		chk(32'(gate_drive), 1);
		tick(1000);
		chk(32'(modulation_level > 8'd60 && modulation_level < 8'd110), 1);
		tick(2100);
		chk(32'(modulation_level), 32'h0000_00ff);
		apb(1'b1, `OFS_CTRL, 32'h0000_0000);
		tick(2);
		watch(400);
		chk(32'(rises), 0);
		apb(1'b1, `OFS_CTRL, `CTRL_RESET);
		apb(1'b1, `OFS_MASK, 32'h0000_001f);
		tick(3);
		chk(32'(irq), 1);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk(32'(rd[`STAT_SKIP_BIT]), 1);
		tick(3);
		chk(32'(irq), 0);
		repeat (2)
		begin
			@(posedge pclk);
			feedback_open <= 1'b1;
			tick(3);
			chk(32'(fb_error_flag), 1);
			tick(FLT * 3 / 4);
			@(posedge pclk);
			feedback_open <= 1'b0;
			watch(300);
			chk(32'(rises > 1 && startup_fet_en === 1'b0), 1);
		end
		@(posedge pclk);
		feedback_open <= 1'b1;
		tick(FLT + 5);
		@(posedge pclk);
		feedback_open <= 1'b0;
		watch(150);
		chk(32'(rises), 0);
		hiccup();
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk(32'({rd[`STAT_FB_TIMEOUT_BIT], rd[`STAT_RESTART_BIT]}), 32'd3);
		@(posedge pclk);
		supply_uvlo <= 1'b1;
		@(posedge pclk);
		supply_uvlo <= 1'b0;
		tick(2);
		watch(150);
		chk(32'(rises), 0);
		hiccup();
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk(32'(rd[`STAT_UVLO_BIT]), 1);
		report_and_stop();
	end
endmodule : current_mode_pwm_sequencer_tb
